// >>> rx_regs_params.svh
`ifndef RX_REGS_PARAMS_SVH
`define RX_REGS_PARAMS_SVH
// Functional notes
// - a write-only mode register at local address 6000000 holds the two receiving mode bits.
// - the read-only status word at 6000008 shows the current mode bits, since mode reads back nowhere else.
// - a register read at any undecoded address returns the status word.
// - register transfers are 16 bits wide and every access ends with a ready from the device.
// - ready completes a write in about 144 ns and a read in about 120 ns.
// - the flash sits on a 16-bit bus using only data bits 7..0, so each byte takes two addresses.
// - the receive buffer holds up to 8K entries of 64 bits.
// - each entry is 48 bits of link data plus a 16-bit time stamp.
// - link multiplex logic writes entries and only the processor reads them over the 64-bit bus.
// - a buffer-full flag drives processor gpio pin six, high for full and low for not full.
// - any write to the buffer clear address, or reset, empties the buffer and clears flags and parity error; a parity error in the clear cycle stays set.
// - mode X1 selects frequency controller, 00 gradient controller, 10 digital receiver unit.

// ********************************
// register map (word addresses as printed)
// ********************************
`define ADDR_MODE_SELECT     32'h0600_0000
`define ADDR_BUFFER_CLEAR    32'h0600_0004
`define ADDR_STATE_WORD      32'h0600_0008
`define ADDR_SOURCE_CHANNEL  32'h0600_000A
`define ADDR_BOARD_INFO      32'h6000_0030
`define ADDR_SLOT_REVISION   32'h6000_0038

// ********************************
// fields and reset values
// ********************************
`define MODE_RESET           2'h1
`define CHANNEL_RESET        4'h0
`define STATUS_MODE_LSB      0
`define STATUS_EMPTY_BIT     2
`define STATUS_FULL_BIT      3
`define STATUS_PARITY_BIT    4

// ********************************
// timing
// ********************************
`define CLK_PERIOD_NS        10
`define REG_WRITE_NS         144
`define REG_READ_NS          120
`define REG_WRITE_CYCLES     (`REG_WRITE_NS / `CLK_PERIOD_NS)
`define REG_READ_CYCLES      (`REG_READ_NS / `CLK_PERIOD_NS)
`endif

// >>> rx_regs_pkg.sv
package rx_regs_pkg;
    typedef enum logic [1:0] {
        SRC_GRADIENT = 2'h0,
        SRC_FREQ     = 2'h1,
        SRC_RECEIVER = 2'h2,
        SRC_FREQ_ALT = 2'h3
    } source_mode_t;

    typedef struct packed {
        logic [47:0] link_data;
        logic [15:0] time_stamp;
    } buffer_entry_t;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WAIT  = 2'b01,
        BUS_READY = 2'b11
    } bus_state_t;
endpackage

// >>> skid_buffer.sv
`timescale 1ns/1ps
// two-entry buffer; a stall downstream never drops a word
module skid_buffer
    import rx_regs_pkg::*;
#(
    parameter int WIDTH = 64
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] slot_q [2];
    logic [1:0]       count_q;
    logic             head_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire logic        tail = head_q ^ count_q[0];
    logic             ready_q;
    wire logic [1:0]  count_d = count_q + {1'b0, push} - {1'b0, pop};

    // ready is registered from the next count so the upstream port sees a flop
    assign in_ready  = ready_q;
    assign out_valid = (count_q != 2'd0);
    assign out_data  = slot_q[head_q];

    // occupancy and pointers; flush empties in one cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 2'd0;
            head_q  <= 1'b0;
            ready_q <= 1'b1;
        end else if (flush) begin
            count_q <= 2'd0;
            head_q  <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            count_q <= count_d;
            ready_q <= (count_d != 2'd2);
            if (pop) head_q <= ~head_q;
        end
    end

    // storage
    always_ff @(posedge sys_clk) begin
        if (push) slot_q[tail] <= in_data;
    end
endmodule

// >>> entry_store.sv
`timescale 1ns/1ps
// receive buffer store, flip-flop array addressed by index
module entry_store
    import rx_regs_pkg::*;
#(
    parameter int DEPTH = 8192,
    parameter int AW    = 13
) (
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire logic          flush,
    input  wire buffer_entry_t wr_entry,
    input  wire logic          wr_valid,
    output logic               wr_ready,
    input  wire logic          rd_pop,
    output buffer_entry_t      rd_entry,
    output logic               empty,
    output logic               full
);
    buffer_entry_t mem_q [DEPTH];
    logic [AW:0]   wr_ptr_q;
    logic [AW:0]   rd_ptr_q;
    wire           do_wr = wr_valid && !full;
    wire           do_rd = rd_pop && !empty;

    assign empty    = (wr_ptr_q == rd_ptr_q);
    assign full     = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign wr_ready = !full;
    assign rd_entry = mem_q[rd_ptr_q[AW-1:0]];

    // pointers; a clear resets both so content is gone
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (do_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
            if (do_rd) rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (do_wr) mem_q[wr_ptr_q[AW-1:0]] <= wr_entry;
    end
endmodule

// >>> rx_board_local_bus_registers.sv
`timescale 1ns/1ps
`include "rx_regs_params.svh"
// ************************************************
// receive board front end: register bus, buffer, full flag
// ************************************************
module rx_board_local_bus_registers
    import rx_regs_pkg::*;
#(
    parameter int         DEPTH      = 8192,
    parameter int         AW         = 13,
    parameter logic [15:0] BOARD_INFO = 16'h8000, // arbitrary value
    parameter logic [15:0] SLOT_REV   = 16'h2A5C  // arbitrary value
) (
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    // narrow memory bus, register space
    input  wire logic          reg_sel,
    input  wire logic          reg_wr,
    input  wire logic [31:0]   reg_addr,
    input  wire logic [15:0]   reg_wdata,
    output logic      [15:0]   reg_rdata,
    output logic               reg_ready,
    // link multiplex logic side
    input  wire buffer_entry_t link_entry,
    input  wire logic          link_valid,
    input  wire logic          link_parity_err,
    output logic               link_ready,
    // wide memory bus buffer read port
    input  wire logic          buf_rd,
    output buffer_entry_t      buf_data,
    output logic               buf_data_valid,
    // status towards the board
    output logic               gpio_pin_six,
    output logic [1:0]         source_mode,
    output logic [3:0]         channel_display
);
    localparam logic [3:0] WR_CYC = 4'(`REG_WRITE_CYCLES);
    localparam logic [3:0] RD_CYC = 4'(`REG_READ_CYCLES);

    bus_state_t  state_q;
    bus_state_t  state_d;
    logic [3:0]  cnt_q;
    logic [1:0]  mode_q;
    logic [3:0]  chan_q;
    logic        parity_q;
    logic [15:0] rdata_q;
    logic        full_q;
    buffer_entry_t buf_data_q;
    logic        buf_valid_q;

    // ********************************
    // address decode
    // ********************************
    wire hit_mode  = (reg_addr == `ADDR_MODE_SELECT);
    wire hit_clear = (reg_addr == `ADDR_BUFFER_CLEAR);
    wire hit_chan  = (reg_addr == `ADDR_SOURCE_CHANNEL);
    wire hit_info  = (reg_addr == `ADDR_BOARD_INFO);
    wire hit_slot  = (reg_addr == `ADDR_SLOT_REVISION);
    wire start     = (state_q == BUS_IDLE) && reg_sel;
    wire finish    = (state_q == BUS_WAIT) && (cnt_q == 4'h1);
    wire wr_commit = finish && reg_wr;
    wire flush     = wr_commit && hit_clear;

    // ********************************
    // receive buffer path
    // ********************************
    buffer_entry_t skid_data;
    logic          skid_valid;
    logic          store_ready;
    logic          store_empty;
    logic          store_full;
    buffer_entry_t store_entry;

    // entries from the link pass a two-entry buffer so a full store stalls, not drops
    skid_buffer #(.WIDTH(64)) u_skid (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .flush     (flush),
        .in_data   (link_entry),
        .in_valid  (link_valid),
        .in_ready  (link_ready),
        .out_data  (skid_data),
        .out_valid (skid_valid),
        .out_ready (store_ready)
    );

    // 8K x 64 store, written only by the link side
    entry_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .flush    (flush),
        .wr_entry (skid_data),
        .wr_valid (skid_valid),
        .wr_ready (store_ready),
        .rd_pop   (buf_rd),
        .rd_entry (store_entry),
        .empty    (store_empty),
        .full     (store_full)
    );

    // status word assembly
    wire [15:0] status_word = {11'h000, parity_q, store_full, store_empty, mode_q};

    // read mux; anything undecoded returns status
    // all sixteen lines carry register data; only the flash lane is byte wide
    wire [15:0] rd_mux = hit_chan ? {12'h000, chan_q} :
                         hit_info ? BOARD_INFO :
                         hit_slot ? SLOT_REV : status_word;

    // ********************************
    // ready handshake state machine
    // ********************************
    // write and read durations differ, so the wait length is chosen at start
    always_comb begin
        state_d = state_q;
        case (state_q)
            BUS_IDLE: begin
                if (reg_sel) state_d = BUS_WAIT;
            end
            BUS_WAIT: begin
                if (cnt_q == 4'h1) state_d = BUS_READY;
            end
            BUS_READY: begin
                if (!reg_sel) state_d = BUS_IDLE;
            end
            default: state_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= BUS_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            if (start) cnt_q <= reg_wr ? (WR_CYC - 4'h1) : (RD_CYC - 4'h1);
            else if (state_q == BUS_WAIT) cnt_q <= cnt_q - 4'h1;
        end
    end

    // ready and read data registered; ready holds until select drops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_ready <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            reg_ready <= finish || (state_q == BUS_READY && reg_sel);
            if (finish && !reg_wr) rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = rdata_q;

    // ********************************
    // control registers
    // ********************************
    // mode resets to frequency controller writable, not readable here
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `MODE_RESET;
            chan_q <= `CHANNEL_RESET;
        end else if (wr_commit) begin
            if (hit_mode) mode_q <= reg_wdata[1:0];
            if (hit_chan) chan_q <= reg_wdata[3:0];
        end
    end

    // parity error is sticky; a new error in the clear cycle still wins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) parity_q <= 1'b0;
        else if (link_parity_err) parity_q <= 1'b1;
        else if (flush) parity_q <= 1'b0;
    end

    // ********************************
    // outputs to processor pins and display
    // ********************************
    // full flag to gpio pin six: high is full
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            full_q      <= 1'b0;
            buf_data_q  <= '0;
            buf_valid_q <= 1'b0;
        end else begin
            full_q      <= store_full && !flush;
            buf_data_q  <= store_entry;
            buf_valid_q <= !store_empty && !flush;
        end
    end
    assign gpio_pin_six    = full_q;
    assign buf_data        = buf_data_q;
    assign buf_data_valid  = buf_valid_q;
    assign source_mode     = mode_q;
    assign channel_display = chan_q;
endmodule

// >>> rx_board_asserts.sv
`timescale 1ns/1ps
`include "rx_regs_params.svh"
// ****************
// register bus checks
// ****************
module rx_bus_checker
    import rx_regs_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        reg_sel,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_ready,
    input wire logic        buf_data_valid,
    input wire logic        gpio_pin_six,
    input wire logic [1:0]  source_mode
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // mode and clear are write-only, so reads there are left unchecked
    wire rd_on = reg_ready && reg_sel && !reg_wr;
    wire wr_on = reg_sel && reg_wr;
    wire odd   = !(reg_addr inside {`ADDR_MODE_SELECT, `ADDR_BUFFER_CLEAR, `ADDR_STATE_WORD,
                                    `ADDR_SOURCE_CHANNEL, `ADDR_BOARD_INFO, `ADDR_SLOT_REVISION});
    AST_WR_TIME: assert property ($rose(reg_sel) && reg_wr |->
        !reg_ready [*8] ##[6:8] $rose(reg_ready)) else $error("write ready off time");
    AST_RD_TIME: assert property ($rose(reg_sel) && !reg_wr |->
        !reg_ready [*8] ##[4:6] $rose(reg_ready)) else $error("read ready off time");
    AST_HOLD: assert property (reg_ready && reg_sel |=> reg_ready && $stable(reg_rdata))
        else $error("ready or read data moved while selected");
    AST_RELEASE: assert property (!reg_sel |=> !reg_ready)
        else $error("ready stands without select");
    AST_STATUS_MODE: assert property (rd_on && reg_addr == `ADDR_STATE_WORD |->
        reg_rdata[1:0] == source_mode) else $error("status lacks mode");
    AST_UNMAPPED: assert property (rd_on && odd |-> reg_rdata[1:0] == source_mode)
        else $error("undecoded read is not status");
    AST_MODE_WR: assert property (wr_on && $rose(reg_ready) && reg_addr == `ADDR_MODE_SELECT
        |-> source_mode == reg_wdata[1:0]) else $error("mode write lost");
    AST_CLEAR: assert property (wr_on && $rose(reg_ready) && reg_addr == `ADDR_BUFFER_CLEAR
        |-> !buf_data_valid && !gpio_pin_six) else $error("clear left data");
    AST_RST_MODE: assert property ($rose(reset_n) |-> source_mode == `MODE_RESET)
        else $error("mode not 01 after reset");
endmodule

bind rx_board_local_bus_registers rx_bus_checker u_chk (
    .sys_clk, .reset_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ready, .buf_data_valid, .gpio_pin_six, .source_mode
);

// >>> cpu_bus_model.sv
`timescale 1ns/1ps
// ****************
// processor master on the register space
// ****************
module cpu_bus_model (
    input  wire logic        sys_clk,
    output logic             reg_sel,
    output logic             reg_wr,
    output logic [31:0]      reg_addr,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ready
);
    // flash cycles are counted out by the processor, so no ready wait applies there
    initial begin
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 32'h0;
        reg_wdata = 16'h0;
    end
    // request held until ready, then h more cycles (a slow master)
    task automatic access(input logic w, input logic [31:0] a, input logic [15:0] d,
                          input int h, output logic [15:0] q);
        int k;
        k = 0;
        @(negedge sys_clk);
        reg_sel = 1'b1;
        reg_wr = w;
        reg_addr = a;
        reg_wdata = d;
        while (reg_ready !== 1'b1 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        q = reg_rdata;
        repeat (h) @(negedge sys_clk);
        reg_sel = 1'b0;
        // released lines show the inverse, so a stale copy cannot pass
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// >>> test_rx_board_local_bus_registers.sv
`timescale 1ns/1ps
`include "rx_regs_params.svh"
// ****************
// bench: master model, link source, reference queue
// ****************
module test_rx_board_local_bus_registers
    import rx_regs_pkg::*;
;
    localparam int DEPTH = 16;
    localparam logic [15:0] INFO_VAL = 16'h8421; // arbitrary value
    localparam logic [15:0] SLOT_VAL = 16'h1A2B; // arbitrary value
    logic          sys_clk, reset_n, reg_sel, reg_wr, reg_ready;
    logic [31:0]   reg_addr;
    logic [15:0]   reg_wdata, reg_rdata, rd, d;
    buffer_entry_t link_entry, buf_data;
    logic          link_valid, link_parity_err, link_ready, buf_rd, buf_data_valid;
    logic          gpio_pin_six, m_par;
    logic [1:0]    source_mode, m_mode;
    logic [3:0]    channel_display, m_chan;
    int            failures, checks, seed, cyc;
    buffer_entry_t q[$];

    rx_board_local_bus_registers #(.DEPTH(DEPTH), .AW(4), .BOARD_INFO(INFO_VAL),
                                   .SLOT_REV(SLOT_VAL)) u_dut (
        .sys_clk, .reset_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_ready, .link_entry, .link_valid, .link_parity_err, .link_ready, .buf_rd,
        .buf_data, .buf_data_valid, .gpio_pin_six, .source_mode, .channel_display
    );
    cpu_bus_model u_cpu (
        .sys_clk, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_ready
    );
    // clock, and a cycle ceiling that cuts a hang short
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // status read, prompt or slow release by chance
    task automatic read_status(input logic [31:0] a);
        u_cpu.access(1'b0, a, 16'h0000, $unsigned($random(seed)) % 2, rd);
        chk("status", rd, {11'h000, m_par, q.size() >= DEPTH, q.size() == 0, m_mode});
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        u_cpu.access(1'b1, a, v, 1, rd);
    endtask
    // random offers; a word counts only where valid meets ready
    task automatic push(input int k);
        repeat (k) begin
            @(negedge sys_clk);
            link_valid = 1'($random(seed));
            link_entry = {$random(seed), $random(seed)};
            #1;
            if (link_valid && link_ready)
                q.push_back(link_entry);
        end
        @(negedge sys_clk);
        link_valid = 1'b0;
    endtask
    initial begin
        seed = 95;
        reset_n = 1'b0;
        link_entry = '0;
        link_valid = 1'b0;
        link_parity_err = 1'b0;
        buf_rd = 1'b0;
        m_mode = `MODE_RESET;
        m_chan = `CHANNEL_RESET;
        m_par = 1'b0;
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        read_status(`ADDR_STATE_WORD);
        // every mode code under random upper bits, ending on 01
        for (int i = 1; i < 6; i++) begin
            d = 16'($random(seed));
            d[1:0] = 2'(i);
            m_mode = 2'(i);
            wr(`ADDR_MODE_SELECT, d);
            chk("mode", source_mode, m_mode);
            read_status(`ADDR_STATE_WORD);
            read_status(32'h0600_0100 + 32'(4 * i));
        end
        d = 16'($random(seed));
        m_chan = d[3:0];
        wr(`ADDR_SOURCE_CHANNEL, d);
        u_cpu.access(1'b0, `ADDR_SOURCE_CHANNEL, 16'h0000, 0, rd);
        chk("channel", rd, {12'h000, m_chan});
        chk("display", channel_display, m_chan);
        // writes to read-only or undecoded addresses change nothing
        wr(`ADDR_STATE_WORD, 16'hFFFE);
        wr(32'h0600_0100, 16'hFFFE);
        chk("mode kept", source_mode, m_mode);
        chk("display kept", channel_display, m_chan);
        // identity words read back as strapped at the instance
        u_cpu.access(1'b0, `ADDR_BOARD_INFO, 16'h0000, 1, rd);
        chk("board info", rd, INFO_VAL);
        u_cpu.access(1'b0, `ADDR_SLOT_REVISION, 16'h0000, 0, rd);
        chk("slot revision", rd, SLOT_VAL);
        // fill while the reader stalls, then drain in order
        push(80);
        chk("accepted", q.size(), DEPTH + 2);
        chk("full pin", gpio_pin_six, 1'b1);
        chk("refused", link_ready, 1'b0);
        read_status(`ADDR_STATE_WORD);
        while (q.size() > 0) begin
            @(negedge sys_clk);
            if (buf_data_valid === 1'b1) begin
                chk("entry", buf_data, q.pop_front());
                buf_rd = 1'b1;
                @(negedge sys_clk);
                buf_rd = 1'b0;
                repeat (2) @(negedge sys_clk);
            end
        end
        repeat (3) @(negedge sys_clk);
        chk("full pin low", gpio_pin_six, 1'b0);
        // parity flag and data both go on clear
        push(6);
        link_parity_err = 1'b1;
        @(negedge sys_clk);
        link_parity_err = 1'b0;
        m_par = 1'b1;
        read_status(`ADDR_STATE_WORD);
        wr(`ADDR_BUFFER_CLEAR, 16'($random(seed)));
        q.delete();
        m_par = 1'b0;
        read_status(`ADDR_STATE_WORD);
        chk("cleared", buf_data_valid, 1'b0);
        // mid-run reset brings mode and channel home
        wr(`ADDR_MODE_SELECT, 16'h0002);
        chk("mode before reset", source_mode, 2'h2);
        @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        m_mode = `MODE_RESET;
        m_chan = `CHANNEL_RESET;
        chk("mode reset", source_mode, m_mode);
        chk("display reset", channel_display, m_chan);
        read_status(`ADDR_STATE_WORD);
        final_report();
    end
endmodule
